// *** logic/msss_pkg.sv ***
package msss_pkg;

   // bus geometry
   localparam int unsigned BUS_BITS      = 128;
   localparam int unsigned SEG_BITS      = 64;
   localparam int unsigned SEG_COUNT     = 2;
   localparam int unsigned SEG_BYTES     = 8;
   localparam int unsigned BUS_BYTES     = 16;
   localparam int unsigned EMPTY_BITS    = 3;
   localparam int unsigned LANE_BITS     = 5;
   localparam int unsigned LEN_BITS      = 14;

   // byte counts at the width of the lane counter
   localparam logic [4:0]  SEG_BYTES_W   = 5'h08;

   // frame length checking
   localparam logic [13:0] LEN_WORD      = 14'h0010;
   localparam logic [13:0] LEN_MIN       = 14'h0040;
   localparam logic [13:0] LEN_MAX       = 14'h2400;
   localparam logic [13:0] LEN_SAT       = 14'h3fff;
   localparam logic [13:0] LEN_RESET     = 14'h0000;

   // reset values of the stream outputs
   localparam logic [2:0]  EMPTY_RESET   = 3'h0;
   localparam logic        FLAG_RESET    = 1'b0;

   typedef enum logic [1:0]
   {
      RX_IDLE  = 2'b01,
      RX_FRAME = 2'b10
   } msss_rx_state_t;

endpackage : msss_pkg

// *** logic/msss_length_check.sv ***
`timescale 1ns/1ps
module msss_length_check
(
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic        word_take_i,
   input  wire logic        frame_start_i,
   input  wire logic        frame_end_i,
   input  wire logic [4:0]  last_bytes_i,
   output logic             length_bad_o
);

   logic [13:0] count_r;
   logic [13:0] base;
   logic [13:0] word_bytes;
   logic [14:0] total;
   logic [13:0] total_sat;

   // running length including the word now offered; saturates so giants stay giants
   always_comb
   begin
      word_bytes   = frame_end_i ? {9'h000, last_bytes_i} : msss_pkg::LEN_WORD;
      base         = frame_start_i ? msss_pkg::LEN_RESET : count_r;
      total        = {1'b0, base} + {1'b0, word_bytes};
      total_sat    = total[14] ? msss_pkg::LEN_SAT : total[13:0];
      length_bad_o = frame_end_i && ((total_sat < msss_pkg::LEN_MIN) || (total_sat > msss_pkg::LEN_MAX));
   end

   // count only words really taken into a frame
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         count_r <= msss_pkg::LEN_RESET;
      else if (word_take_i)
         count_r <= frame_end_i ? msss_pkg::LEN_RESET : total_sat;
   end

endmodule : msss_length_check

// *** logic/msss_segment_qualify.sv ***
`timescale 1ns/1ps
module msss_segment_qualify
(
   input  wire logic        word_valid_i,
   input  wire logic        frame_start_i,
   input  wire logic        frame_end_i,
   input  wire logic [4:0]  last_bytes_i,
   output logic [1:0]       enable_o,
   output logic [1:0]       start_o,
   output logic [1:0]       end_o,
   output logic [5:0]       empty_o,
   output logic [15:0]      byte_keep_o
);

   // per segment qualifiers; a segment is live unless the frame ended below it
   for (genvar s = 0; s < msss_pkg::SEG_COUNT; s++)
   begin : g_seg
      localparam logic [4:0] LO = 5'(s * msss_pkg::SEG_BYTES);
      localparam logic [4:0] HI = 5'((s + 1) * msss_pkg::SEG_BYTES);
      logic       present;
      logic       is_end;
      logic [4:0] fill;
      logic [4:0] unused;
      assign present = !frame_end_i || (last_bytes_i > LO);
      assign is_end  = frame_end_i && (last_bytes_i > LO) && (last_bytes_i <= HI);
      assign fill    = last_bytes_i - LO;
      assign unused  = msss_pkg::SEG_BYTES_W - fill;
      assign enable_o[s] = word_valid_i && present;
      assign start_o[s]  = word_valid_i && frame_start_i && (s == 0);
      assign end_o[s]    = word_valid_i && is_end;
      // only the closing segment may report empty lanes
      assign empty_o[3*s +: 3] = (word_valid_i && is_end) ? unused[2:0] : msss_pkg::EMPTY_RESET;
   end

   // lanes past the last valid byte are blanked so stale bytes never leak out
   for (genvar b = 0; b < msss_pkg::BUS_BYTES; b++)
   begin : g_byte
      assign byte_keep_o[b] = !frame_end_i || (last_bytes_i > 5'(b));
   end

endmodule : msss_segment_qualify

// *** logic/msss_client_stream.sv ***
`timescale 1ns/1ps
module msss_client_stream
(
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   // receive words from the mac receive path
   input  wire logic         in_valid_i,
   input  wire logic         in_start_i,
   input  wire logic         in_end_i,
   input  wire logic [4:0]   in_last_bytes_i,
   input  wire logic [127:0] in_data_i,
   input  wire logic         in_fcs_bad_i,
   input  wire logic         in_block_bad_i,
   // receive stream to the client
   output logic              receive_valid_o,
   output logic [127:0]      receive_data_o,
   output logic              receive_segment0_enable_o,
   output logic              receive_segment1_enable_o,
   output logic              receive_segment0_frame_start_o,
   output logic              receive_segment1_frame_start_o,
   output logic              receive_segment0_frame_end_o,
   output logic              receive_segment1_frame_end_o,
   output logic              receive_segment0_bad_frame_o,
   output logic              receive_segment1_bad_frame_o,
   output logic [2:0]        receive_segment0_empty_count_o,
   output logic [2:0]        receive_segment1_empty_count_o,
   // transmit stream from the client
   input  wire logic         tx_core_ready_i,
   output logic              tx_ready_o,
   input  wire logic         tx_valid_i,
   input  wire logic [127:0] tx_data_i,
   output logic              tx_word_valid_o,
   output logic [127:0]      tx_word_o
);

   ////////////////////////////////////////////////////////////////////////////
   // receive framing

   msss_pkg::msss_rx_state_t rx_state_r;
   msss_pkg::msss_rx_state_t rx_state_nxt;
   logic                     word_take;
   logic                     block_bad_r;
   logic                     block_bad_now;
   logic                     length_bad;
   logic                     frame_bad;
   logic [1:0]               seg_enable;
   logic [1:0]               seg_start;
   logic [1:0]               seg_end;
   logic [5:0]               seg_empty;
   logic [15:0]              byte_keep;
   logic [127:0]             data_masked;

   // orphan words outside a frame are dropped; a new start always opens a frame
   assign word_take = in_valid_i && ((rx_state_r == msss_pkg::RX_FRAME) || in_start_i);

   always_comb
   begin
      rx_state_nxt = rx_state_r;
      unique case (rx_state_r)
         msss_pkg::RX_IDLE:
         begin
            if (word_take && !in_end_i)
               rx_state_nxt = msss_pkg::RX_FRAME;
         end
         msss_pkg::RX_FRAME:
         begin
            if (word_take && in_end_i)
               rx_state_nxt = msss_pkg::RX_IDLE;
         end
      endcase
   end

   // frame tracking state
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rx_state_r <= msss_pkg::RX_IDLE;
      else
         rx_state_r <= rx_state_nxt;
   end

   // a bad block seen in the same word as the start still counts
   assign block_bad_now = in_block_bad_i || (block_bad_r && !in_start_i);

   // sticky bad-block memory for the frame in flight
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         block_bad_r <= msss_pkg::FLAG_RESET;
      else if (word_take)
         block_bad_r <= in_end_i ? msss_pkg::FLAG_RESET : block_bad_now;
   end

   msss_length_check u_length
   (
      .clock_i       (clock_i),
      .rstn_i        (rstn_i),
      .word_take_i   (word_take),
      .frame_start_i (in_start_i),
      .frame_end_i   (in_end_i),
      .last_bytes_i  (in_last_bytes_i),
      .length_bad_o  (length_bad)
   );

   assign frame_bad = in_end_i && (in_fcs_bad_i || block_bad_now || length_bad);

   msss_segment_qualify u_qualify
   (
      .word_valid_i  (word_take),
      .frame_start_i (in_start_i),
      .frame_end_i   (in_end_i),
      .last_bytes_i  (in_last_bytes_i),
      .enable_o      (seg_enable),
      .start_o       (seg_start),
      .end_o         (seg_end),
      .empty_o       (seg_empty),
      .byte_keep_o   (byte_keep)
   );

   // byte n of the frame stays on lane n, lane 0 at bits 7:0
   for (genvar b = 0; b < msss_pkg::BUS_BYTES; b++)
   begin : g_mask
      assign data_masked[8*b +: 8] = byte_keep[b] ? in_data_i[8*b +: 8] : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive output registers

   logic         rx_valid_r;
   logic [127:0] rx_data_r;
   logic [1:0]   rx_enable_r;
   logic [1:0]   rx_start_r;
   logic [1:0]   rx_end_r;
   logic [1:0]   rx_bad_r;
   logic [5:0]   rx_empty_r;

   // one word in, one word out the next edge; no buffer, so no gaps appear
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_valid_r  <= msss_pkg::FLAG_RESET;
         rx_data_r   <= 128'h0;
         rx_enable_r <= 2'h0;
         rx_start_r  <= 2'h0;
         rx_end_r    <= 2'h0;
         rx_bad_r    <= 2'h0;
         rx_empty_r  <= 6'h00;
      end
      else
      begin
         rx_valid_r  <= word_take;
         rx_data_r   <= word_take ? data_masked : 128'h0;
         rx_enable_r <= seg_enable;
         rx_start_r  <= seg_start;
         rx_end_r    <= seg_end;
         rx_bad_r    <= seg_end & {2{frame_bad}};
         rx_empty_r  <= seg_empty;
      end
   end

   // all receive outputs come straight from flops on clock_i
   assign receive_valid_o                = rx_valid_r;
   assign receive_data_o                 = rx_data_r;
   assign receive_segment0_enable_o      = rx_enable_r[0];
   assign receive_segment1_enable_o      = rx_enable_r[1];
   assign receive_segment0_frame_start_o = rx_start_r[0];
   assign receive_segment1_frame_start_o = rx_start_r[1];
   assign receive_segment0_frame_end_o   = rx_end_r[0];
   assign receive_segment1_frame_end_o   = rx_end_r[1];
   assign receive_segment0_bad_frame_o   = rx_bad_r[0];
   assign receive_segment1_bad_frame_o   = rx_bad_r[1];
   assign receive_segment0_empty_count_o = rx_empty_r[2:0];
   assign receive_segment1_empty_count_o = rx_empty_r[5:3];

   ////////////////////////////////////////////////////////////////////////////
   // transmit handshake

   logic         tx_ready_r;
   logic         tx_take;
   logic         tx_word_valid_r;
   logic [127:0] tx_word_r;

   // ready is registered so the client sees a clean level for a whole cycle
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         tx_ready_r <= msss_pkg::FLAG_RESET;
      else
         tx_ready_r <= tx_core_ready_i;
   end

   // anything offered while not ready is simply not taken
   assign tx_take = tx_valid_i && tx_ready_r;

   // client inputs sampled on the same edge that drives ready
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_word_valid_r <= msss_pkg::FLAG_RESET;
         tx_word_r       <= 128'h0;
      end
      else
      begin
         tx_word_valid_r <= tx_take;
         if (tx_take)
            tx_word_r <= tx_data_i;
      end
   end

   assign tx_ready_o      = tx_ready_r;
   assign tx_word_valid_o = tx_word_valid_r;
   assign tx_word_o       = tx_word_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_valid_enable;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_valid_o == receive_segment0_enable_o;
   endproperty
   a_valid_enable: assert property (p_valid_enable) else $error("segment 0 enable differs from valid");

   property p_seg1_needs_valid;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_segment1_enable_o |-> receive_valid_o;
   endproperty
   a_seg1_needs_valid: assert property (p_seg1_needs_valid) else $error("segment 1 enabled without valid");

   property p_empty_zero_mid;
      @(posedge clock_i) disable iff (!rstn_i)
      !(receive_segment0_frame_end_o || receive_segment1_frame_end_o)
         |-> (receive_segment0_empty_count_o == 3'h0) && (receive_segment1_empty_count_o == 3'h0);
   endproperty
   a_empty_zero_mid: assert property (p_empty_zero_mid) else $error("empty count set outside end cycle");

   property p_gapless;
      @(posedge clock_i) disable iff (!rstn_i)
      (rx_state_r == msss_pkg::RX_FRAME) && in_valid_i |=> receive_valid_o;
   endproperty
   a_gapless: assert property (p_gapless) else $error("frame word not delivered next cycle");

   property p_short_frame;
      @(posedge clock_i) disable iff (!rstn_i)
      in_valid_i && in_start_i && in_end_i
         |=> receive_segment0_frame_start_o && (receive_segment0_frame_end_o || receive_segment1_frame_end_o)
             && (receive_segment0_bad_frame_o || receive_segment1_bad_frame_o);
   endproperty
   a_short_frame: assert property (p_short_frame) else $error("one-word frame lacks start, end or length error");

   property p_fcs_error;
      @(posedge clock_i) disable iff (!rstn_i)
      word_take && in_end_i && in_fcs_bad_i |=> receive_segment0_bad_frame_o || receive_segment1_bad_frame_o;
   endproperty
   a_fcs_error: assert property (p_fcs_error) else $error("fcs failure not flagged");

   property p_bad_qualified;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_segment1_bad_frame_o |-> receive_segment1_enable_o && receive_segment1_frame_end_o && receive_valid_o;
   endproperty
   a_bad_qualified: assert property (p_bad_qualified) else $error("error flag outside qualified end cycle");

   property p_seg1_end_full0;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_segment1_frame_end_o |-> receive_segment1_enable_o && !receive_segment0_frame_end_o;
   endproperty
   a_seg1_end_full0: assert property (p_seg1_end_full0) else $error("end in segment 1 not qualified");

   property p_first_byte;
      @(posedge clock_i) disable iff (!rstn_i)
      word_take && in_start_i && (!in_end_i || (in_last_bytes_i > 5'h01))
         |=> receive_data_o[15:0] == $past(in_data_i[15:0]);
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("first bytes not on low lanes");

   property p_tx_take;
      @(posedge clock_i) disable iff (!rstn_i)
      tx_word_valid_o |-> $past(tx_valid_i) && $past(tx_ready_o);
   endproperty
   a_tx_take: assert property (p_tx_take) else $error("transmit word taken without valid and ready");

   property p_tx_stall;
      @(posedge clock_i) disable iff (!rstn_i)
      !tx_ready_o ##1 1'b1 |-> !tx_word_valid_o;
   endproperty
   a_tx_stall: assert property (p_tx_stall) else $error("transmit word taken while not ready");

   property p_bad0_qualified;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_segment0_bad_frame_o |-> receive_segment0_enable_o && receive_segment0_frame_end_o && receive_valid_o;
   endproperty
   a_bad0_qualified: assert property (p_bad0_qualified) else $error("segment 0 error flag unqualified");

   property p_block_error;
      @(posedge clock_i) disable iff (!rstn_i)
      word_take && in_end_i && in_block_bad_i |=> receive_segment0_bad_frame_o || receive_segment1_bad_frame_o;
   endproperty
   a_block_error: assert property (p_block_error) else $error("bad block in end word not flagged");

   property p_mid_full;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_valid_o && !receive_segment0_frame_end_o && !receive_segment1_frame_end_o
         |-> receive_segment1_enable_o;
   endproperty
   a_mid_full: assert property (p_mid_full) else $error("non-final word not full width");

   property p_end0_closes;
      @(posedge clock_i) disable iff (!rstn_i)
      receive_segment0_frame_end_o |-> !receive_segment1_enable_o && (receive_data_o[127:64] == 64'h0);
   endproperty
   a_end0_closes: assert property (p_end0_closes) else $error("segment 1 live after end in segment 0");

   property p_idle_quiet;
      @(posedge clock_i) disable iff (!rstn_i)
      !receive_valid_o |-> (receive_data_o == 128'h0) && !receive_segment0_frame_start_o
         && !receive_segment0_frame_end_o && !receive_segment1_frame_end_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("qualifiers active while valid is low");

   property p_no_orphan;
      @(posedge clock_i) disable iff (!rstn_i)
      !word_take |=> !receive_valid_o;
   endproperty
   a_no_orphan: assert property (p_no_orphan) else $error("word delivered that was never taken");

endmodule : msss_client_stream

// *** tb/msss_client_model.sv ***
`timescale 1ns/1ps
// behavioural client: takes every receive word, offers transmit words
module msss_client_model
(
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   input  wire logic         offer_i,
   input  wire logic [127:0] offer_data_i,
   input  wire logic         tx_ready_i,
   output logic              tx_valid_o,
   output logic [127:0]      tx_data_o,
   input  wire logic         rx_valid_i,
   input  wire logic         rx_end0_i,
   input  wire logic         rx_end1_i,
   output logic [15:0]       frames_o
);

   logic         pending_r;
   logic [127:0] word_r;

   ////////////////////////////////////////////////////////////////////////////////
   // offer withdrawn in the very cycle ready falls
   assign tx_valid_o = pending_r & tx_ready_i;
   // idle bus shows the inverse so stale data never passes for a word
   assign tx_data_o  = pending_r ? word_r : ~word_r;

   // a word is held until taken, then the next offer is loaded
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pending_r <= 1'b0;
         word_r    <= 128'h0;
      end
      else if (!pending_r || tx_valid_o)
      begin
         pending_r <= offer_i;
         word_r    <= offer_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // never stalls; qualifiers ignored while valid is low
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         frames_o <= 16'h0;
      else if (rx_valid_i && (rx_end0_i || rx_end1_i))
         frames_o <= frames_o + 16'h1;
   end

endmodule : msss_client_model

// *** tb/test_msss_client_stream.sv ***
`timescale 1ns/1ps
module test_msss_client_stream;

   typedef struct { logic [142:0] vec; int due; } msss_note_t;

   logic         clock_i;
   logic         rstn_i;
   logic         in_valid_i;
   logic         in_start_i;
   logic         in_end_i;
   logic [4:0]   in_last_bytes_i;
   logic [127:0] in_data_i;
   logic         in_fcs_bad_i;
   logic         in_block_bad_i;
   logic         rv;
   logic [127:0] rdata;
   logic [1:0]   en;
   logic [1:0]   st;
   logic [1:0]   fe;
   logic [1:0]   bad;
   logic [2:0]   emp0;
   logic [2:0]   emp1;
   logic         tx_core_ready_i;
   logic         tx_ready_o;
   logic         tx_valid_i;
   logic [127:0] tx_data_i;
   logic         tx_word_valid_o;
   logic [127:0] tx_word_o;
   logic         offer;
   logic [127:0] offer_data;
   logic [15:0]  frames;
   logic         ready_prev;
   logic [31:0]  seed;
   logic [31:0]  tx_seed;
   int           failures;
   int           comparisons;
   int           cyc;
   int           frames_sent;
   msss_note_t   rxq[$];
   msss_note_t   txq[$];
   int           f_len[12] = '{73, 73, 64, 64, 63, 16, 8, 1, 24, 80, 9216, 9217};
   bit           f_fcs[12] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
   int           f_blk[12] = '{-1, 2, -1, -1, -1, -1, 0, -1, -1, 0, -1, -1};
   wire  [142:0] rx_vec = {rv, en, st, fe, bad, emp0, emp1, rdata};

   msss_client_stream u_msss_client_stream
   (
      .clock_i                        (clock_i),
      .rstn_i                         (rstn_i),
      .in_valid_i                     (in_valid_i),
      .in_start_i                     (in_start_i),
      .in_end_i                       (in_end_i),
      .in_last_bytes_i                (in_last_bytes_i),
      .in_data_i                      (in_data_i),
      .in_fcs_bad_i                   (in_fcs_bad_i),
      .in_block_bad_i                 (in_block_bad_i),
      .receive_valid_o                (rv),
      .receive_data_o                 (rdata),
      .receive_segment0_enable_o      (en[1]),
      .receive_segment1_enable_o      (en[0]),
      .receive_segment0_frame_start_o (st[1]),
      .receive_segment1_frame_start_o (st[0]),
      .receive_segment0_frame_end_o   (fe[1]),
      .receive_segment1_frame_end_o   (fe[0]),
      .receive_segment0_bad_frame_o   (bad[1]),
      .receive_segment1_bad_frame_o   (bad[0]),
      .receive_segment0_empty_count_o (emp0),
      .receive_segment1_empty_count_o (emp1),
      .tx_core_ready_i                (tx_core_ready_i),
      .tx_ready_o                     (tx_ready_o),
      .tx_valid_i                     (tx_valid_i),
      .tx_data_i                      (tx_data_i),
      .tx_word_valid_o                (tx_word_valid_o),
      .tx_word_o                      (tx_word_o)
   );

   msss_client_model u_msss_client_model
   (
      .clock_i      (clock_i),
      .rstn_i       (rstn_i),
      .offer_i      (offer),
      .offer_data_i (offer_data),
      .tx_ready_i   (tx_ready_o),
      .tx_valid_o   (tx_valid_i),
      .tx_data_o    (tx_data_i),
      .rx_valid_i   (rv),
      .rx_end0_i    (fe[1]),
      .rx_end1_i    (fe[0]),
      .frames_o     (frames)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic check(input logic [142:0] seen, input logic [142:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task close_out;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // one word per edge, no gaps; the note is due two edges after driving
   task automatic send_frame(input int len, input bit fcs, input int blk);
      int           n;
      int           lb;
      bit           last;
      bit           bad_f;
      logic [127:0] w;
      logic [127:0] m;
      msss_note_t   note;
      n = (len + 15) / 16;
      bad_f = fcs || len < 64 || len > 9216 || (blk >= 0 && blk < n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock_i);
         last = (i == n - 1);
         lb = last ? len - 16 * (n - 1) : 16;
         for (int k = 0; k < 4; k++)
         begin
            seed = lfsr_next(seed);
            w[32*k +: 32] = seed;
         end
         m = '0;
         for (int b = 0; b < lb; b++)
            m[8*b +: 8] = 8'hff;
         in_valid_i      <= 1'b1;
         in_start_i      <= (i == 0);
         in_end_i        <= last;
         in_last_bytes_i <= lb[4:0];
         in_data_i       <= w;
         in_fcs_bad_i    <= last && fcs;
         in_block_bad_i  <= (i == blk);
         note.due = cyc + 2;
         note.vec = {1'b1, 1'b1, !last || lb > 8, i == 0, 1'b0, last && lb <= 8, last && lb > 8,
                     last && lb <= 8 && bad_f, last && lb > 8 && bad_f,
                     (last && lb <= 8) ? 3'(8 - lb) : 3'h0, (last && lb > 8) ? 3'(16 - lb) : 3'h0, w & m};
         rxq.push_back(note);
      end
      frames_sent++;
   endtask : send_frame

   task automatic go_idle(input int k);
      @(posedge clock_i);
      in_valid_i     <= 1'b0;
      in_start_i     <= 1'b0;
      in_end_i       <= 1'b0;
      in_fcs_bad_i   <= 1'b0;
      in_block_bad_i <= 1'b0;
      repeat (k) @(posedge clock_i);
   endtask : go_idle

   ////////////////////////////////////////////////////////////////////////////////
   // single clock serves both stream directions
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // reference for the ready lag, reset alongside the design
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ready_prev <= 1'b0;
      else
         ready_prev <= tx_core_ready_i;
   end

   // watcher: pre-edge values, so no race with the drivers
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (rxq.size() > 0 && rxq[0].due == cyc)
      begin
         check(rx_vec, rxq[0].vec);
         void'(rxq.pop_front());
      end
      else
         check(rx_vec, 143'h0);
      if (txq.size() > 0 && txq[0].due == cyc)
      begin
         check({14'h0, tx_word_valid_o, tx_word_o}, {14'h0, 1'b1, txq[0].vec[127:0]});
         void'(txq.pop_front());
      end
      else
         check(143'(tx_word_valid_o), 143'h0);
      check(143'(tx_ready_o), 143'(ready_prev));
      if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
         txq.push_back('{vec: {15'h0, tx_data_i}, due: cyc + 1});
   end

   // hang guard
   initial
   begin
      repeat (60000) @(posedge clock_i);
      failures++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {in_valid_i, in_start_i, in_end_i, in_fcs_bad_i, in_block_bad_i} = 5'h00;
      in_last_bytes_i = 5'h00;
      in_data_i       = 128'h0;
      tx_core_ready_i = 1'b0;
      offer           = 1'b0;
      offer_data      = 128'h0;
      seed            = 32'h00000021;
      tx_seed         = 32'h00000021;
      failures        = 0;
      comparisons     = 0;
      cyc             = 0;
      frames_sent     = 0;
      rstn_i          = 1'b0;
      repeat (12) @(posedge clock_i);
      rstn_i <= 1'b1;
      fork
         begin
            // back to back frames over the length and lane boundaries
            for (int f = 0; f < 12; f++)
               send_frame(f_len[f], f_fcs[f], f_blk[f]);
            go_idle(3);
            // orphan word with no open frame must vanish
            @(posedge clock_i);
            in_valid_i      <= 1'b1;
            in_end_i        <= 1'b1;
            in_last_bytes_i <= 5'h10;
            go_idle(3);
            send_frame(73, 1'b0, -1);
            go_idle(5);
         end
         begin
            // random ready and offers; the model must back off at once
            repeat (400)
            begin
               @(posedge clock_i);
               tx_seed = lfsr_next(tx_seed);
               tx_core_ready_i <= tx_seed[0] | tx_seed[1];
               offer           <= tx_seed[2] | tx_seed[3];
               offer_data      <= {4{tx_seed}};
            end
            @(posedge clock_i);
            tx_core_ready_i <= 1'b0;
         end
      join
      repeat (10) @(posedge clock_i);
      check(143'(frames), 143'(frames_sent));
      check(143'(rxq.size() + txq.size()), 143'h0);
      close_out();
   end

endmodule : test_msss_client_stream
